// ---- hdl/msc_pkg.sv ----
package msc_pkg;

    // speed words and register bus
    localparam int SPEED_W       = 24;
    localparam int REG_AW        = 8;
    localparam int REG_DW        = 32;

    // interface cycle timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int CYCLE_TIME_NS = 1000;
    localparam int CYCLE_CLKS    = CYCLE_TIME_NS / CLK_PERIOD_NS;

    // register offsets (byte addresses)
    localparam logic [REG_AW-1:0] REG_FINE_TOL   = 8'h00;
    localparam logic [REG_AW-1:0] REG_COARSE_TOL = 8'h04;
    localparam logic [REG_AW-1:0] REG_STATE      = 8'h08;
    localparam logic [REG_AW-1:0] REG_DIFF       = 8'h0C;
    localparam logic [REG_AW-1:0] REG_IRQ_STAT   = 8'h10;
    localparam logic [REG_AW-1:0] REG_IRQ_MASK   = 8'h14;

    // reset values
    localparam logic [SPEED_W-1:0] FINE_TOL_RST   = 24'h000010;
    localparam logic [SPEED_W-1:0] COARSE_TOL_RST = 24'h000100;

    // state register fields
    localparam int ST_FINE      = 0;
    localparam int ST_COARSE    = 1;
    localparam int ST_COMP      = 2;
    localparam int ST_COUPLE    = 3;
    localparam int ST_CPL_PEND  = 4;
    localparam int ST_COMP_PEND = 5;

    // event bits of status and mask registers
    localparam int EV_COUPLED   = 0;
    localparam int EV_DECOUPLED = 1;
    localparam int EV_COMP_ON   = 2;
    localparam int EV_COMP_OFF  = 3;
    localparam int EV_HELD      = 4;
    localparam int EV_W         = 5;

    typedef enum logic [1:0] {
        CPL_OFF      = 2'b00,
        CPL_WAIT_ON  = 2'b01,
        CPL_ON       = 2'b10,
        CPL_WAIT_OFF = 2'b11
    } msc_cpl_e;

    typedef struct packed {
        logic comp_on_req;
        logic couple_req_lead;
        logic couple_req_follow;
    } msc_req_s;

    typedef struct packed {
        logic lead_pos_ctrl;
        logic follow_pos_ctrl;
        logic lead_standstill;
        logic follow_standstill;
        logic lead_chan_reset;
        logic follow_chan_reset;
    } msc_cond_s;

    typedef struct packed {
        logic couple_active;
        logic comp_active;
        logic coarse_speed_tolerance;
        logic fine_speed_tolerance;
    } msc_stat_s;

endpackage

// ---- hdl/msc_speed_window.sv ----
`timescale 1ns/1ns
module msc_speed_window #(
    parameter int SPEED_W = msc_pkg::SPEED_W
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               srst,
    // interface cycle strobe
    input  wire logic               tick,
    // actual speeds, signed
    input  wire logic [SPEED_W-1:0] lead_speed,
    input  wire logic [SPEED_W-1:0] follow_speed,
    // window limits
    input  wire logic [SPEED_W-1:0] fine_tolerance_param,
    input  wire logic [SPEED_W-1:0] coarse_tolerance_param,
    // results, refreshed on tick
    output logic      [SPEED_W-1:0] diff_q,
    output logic                    fine_q,
    output logic                    coarse_q
);
    if (SPEED_W < 2)
    begin : g_bad_width
        $error("speed width too small");
    end

    // one extra bit so opposite-sign extremes cannot overflow
    wire logic signed [SPEED_W:0] lead_x   = {lead_speed[SPEED_W-1], lead_speed};
    wire logic signed [SPEED_W:0] follow_x = {follow_speed[SPEED_W-1], follow_speed};
    wire logic signed [SPEED_W:0] delta    = lead_x - follow_x;
    wire logic        [SPEED_W:0] mag_w    = delta[SPEED_W] ? (SPEED_W+1)'(-delta) : delta;
    wire logic                    in_fine  = mag_w <= {1'b0, fine_tolerance_param};
    wire logic                    in_coarse = mag_w <= {1'b0, coarse_tolerance_param};

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            diff_q   <= '0;
            fine_q   <= 1'b0;
            coarse_q <= 1'b0;
        end
        else if (tick)
        begin
            // saturate: a difference past full scale reads as all ones
            diff_q   <= mag_w[SPEED_W] ? '1 : mag_w[SPEED_W-1:0]; // [R16]
            fine_q   <= in_fine;                                  // [R10]
            coarse_q <= in_coarse;                                // [R11]
        end
    end

    fine_window_a: assert property (@(posedge clk) disable iff (srst) // [R10]
        tick |=> fine_q == $past(in_fine))
        else $error("fine window flag wrong after interface cycle");

    coarse_window_a: assert property (@(posedge clk) disable iff (srst) // [R11]
        tick |=> coarse_q == $past(in_coarse))
        else $error("coarse window flag wrong after interface cycle");

    flags_hold_a: assert property (@(posedge clk) disable iff (srst) // [R15]
        !tick |=> $stable(fine_q) && $stable(coarse_q) && $stable(diff_q))
        else $error("window flags changed outside interface cycle");

endmodule // msc_speed_window

// ---- hdl/msc_coupling_ctrl.sv ----
// Behaviour
// (R1) comp request rise enables, fall disables
// (R2) compensation starts only with fine tolerance
// (R3) comp request fall switches compensation off
// (R4) coupling request edges couple or decouple
// (R5) switch only under position control, standstill
// (R6) both channels must be in reset
// (R7) unmet conditions: state kept, no alarm; here EV_HELD is set and can raise irq
// (R8) conditions met later: follow request level
// (R9) only the following axis request counts
// (R10) fine flag while speed difference in window
// (R11) coarse flag while difference in window
// (R12) compensation-active status mirrors compensation
// (R13) partner reads compensation status at slave
// (R14) coupling-active status mirrors coupling state
// (R15) status levels refreshed each interface cycle
// (R16) difference is absolute speed difference
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ns
module msc_coupling_ctrl #(
    parameter int CYCLE_CLKS = msc_pkg::CYCLE_CLKS,
    parameter int SPEED_W    = msc_pkg::SPEED_W
) (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        srst,
    // register port
    input  wire logic [msc_pkg::REG_AW-1:0]  reg_addr,
    input  wire logic [msc_pkg::REG_DW-1:0]  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [msc_pkg::REG_DW-1:0]  reg_rdata,
    output logic                             irq,
    // requests from the controller program
    input  wire msc_pkg::msc_req_s           req,
    // axis and channel conditions
    input  wire msc_pkg::msc_cond_s          cond,
    // actual speeds
    input  wire logic [SPEED_W-1:0]          lead_speed,
    input  wire logic [SPEED_W-1:0]          follow_speed,
    // status levels back to the controller program
    output msc_pkg::msc_stat_s               stat
);
    if (CYCLE_CLKS < 2 || CYCLE_CLKS > 4096)
    begin : g_bad_cycle
        $error("interface cycle length out of range");
    end
    if (SPEED_W != msc_pkg::SPEED_W)
    begin : g_bad_width
        $error("speed width must match the package");
    end

    localparam int CW = $clog2(CYCLE_CLKS);
    localparam int DW = msc_pkg::REG_DW;

    // ---- interface cycle strobe
    logic [CW-1:0] cyc_cnt_q;
    wire logic     tick = cyc_cnt_q == CW'(CYCLE_CLKS - 1);

    always_ff @(posedge clk)
    begin
        if (srst)
            cyc_cnt_q <= '0;
        else
            cyc_cnt_q <= tick ? '0 : cyc_cnt_q + CW'(1);
    end

    // ---- registers
    logic [SPEED_W-1:0]          fine_tol_q;
    logic [SPEED_W-1:0]          coarse_tol_q;
    logic [msc_pkg::EV_W-1:0]    ev_stat_q;
    logic [msc_pkg::EV_W-1:0]    ev_mask_q;
    logic [msc_pkg::REG_DW-1:0]  rdata_q;

    wire logic wr_fine   = reg_wr && reg_addr == msc_pkg::REG_FINE_TOL;
    wire logic wr_coarse = reg_wr && reg_addr == msc_pkg::REG_COARSE_TOL;
    wire logic wr_mask   = reg_wr && reg_addr == msc_pkg::REG_IRQ_MASK;
    wire logic rd_stat   = reg_rd && reg_addr == msc_pkg::REG_IRQ_STAT;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            fine_tol_q   <= msc_pkg::FINE_TOL_RST;
            coarse_tol_q <= msc_pkg::COARSE_TOL_RST;
            ev_mask_q    <= '0;
        end
        else
        begin
            if (wr_fine)
                fine_tol_q <= reg_wdata[SPEED_W-1:0];
            if (wr_coarse)
                coarse_tol_q <= reg_wdata[SPEED_W-1:0];
            if (wr_mask)
                ev_mask_q <= reg_wdata[msc_pkg::EV_W-1:0];
        end
    end

    // ---- speed windows
    logic [SPEED_W-1:0] diff_q;
    logic               fine_q;
    logic               coarse_q;

    msc_speed_window #(
        .SPEED_W (SPEED_W)
    ) u_window (
        .clk                    (clk),
        .srst                   (srst),
        .tick                   (tick),
        .lead_speed             (lead_speed),
        .follow_speed           (follow_speed),
        .fine_tolerance_param   (fine_tol_q),
        .coarse_tolerance_param (coarse_tol_q),
        .diff_q                 (diff_q),
        .fine_q                 (fine_q),
        .coarse_q               (coarse_q)
    );

    // ---- request sampling, once per interface cycle
    logic cpl_prev_q;
    logic comp_prev_q;

    // the leading axis copy of the coupling request is never looked at
    wire logic cpl_lvl   = req.couple_req_follow;                      // [R9]
    wire logic cpl_rise  = tick && cpl_lvl && !cpl_prev_q;             // [R4]
    wire logic cpl_fall  = tick && !cpl_lvl && cpl_prev_q;             // [R4]
    wire logic comp_lvl  = req.comp_on_req;
    wire logic comp_rise = tick && comp_lvl && !comp_prev_q;           // [R1]
    wire logic comp_fall = tick && !comp_lvl && comp_prev_q;           // [R1]

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cpl_prev_q  <= 1'b0;
            comp_prev_q <= 1'b0;
        end
        else if (tick)
        begin
            cpl_prev_q  <= cpl_lvl;
            comp_prev_q <= comp_lvl;
        end
    end

    // ---- switching conditions
    wire logic pos_ok   = cond.lead_pos_ctrl && cond.follow_pos_ctrl;        // [R5]
    wire logic still_ok = cond.lead_standstill && cond.follow_standstill;    // [R5]
    wire logic chan_ok  = cond.lead_chan_reset && cond.follow_chan_reset;    // [R6]
    wire logic allowed  = pos_ok && still_ok && chan_ok;

    // ---- coupling state machine
    msc_pkg::msc_cpl_e cpl_q;
    msc_pkg::msc_cpl_e cpl_d;

    always_comb
    begin
        cpl_d = cpl_q;
        case (cpl_q)
            msc_pkg::CPL_OFF:
                if (cpl_rise)
                    cpl_d = allowed ? msc_pkg::CPL_ON : msc_pkg::CPL_WAIT_ON;  // [R7]
            msc_pkg::CPL_WAIT_ON:
                if (tick && !cpl_lvl)
                    cpl_d = msc_pkg::CPL_OFF;                                  // [R8]
                else if (tick && allowed)
                    cpl_d = msc_pkg::CPL_ON;                                   // [R8]
            msc_pkg::CPL_ON:
                if (cpl_fall)
                    cpl_d = allowed ? msc_pkg::CPL_OFF : msc_pkg::CPL_WAIT_OFF; // [R7]
            msc_pkg::CPL_WAIT_OFF:
                if (tick && cpl_lvl)
                    cpl_d = msc_pkg::CPL_ON;                                   // [R8]
                else if (tick && allowed)
                    cpl_d = msc_pkg::CPL_OFF;                                  // [R8]
            default:
                cpl_d = msc_pkg::CPL_OFF;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            cpl_q <= msc_pkg::CPL_OFF;
        else
            cpl_q <= cpl_d;
    end

    wire logic coupled_now  = cpl_q == msc_pkg::CPL_ON || cpl_q == msc_pkg::CPL_WAIT_OFF;
    wire logic coupled_next = cpl_d == msc_pkg::CPL_ON || cpl_d == msc_pkg::CPL_WAIT_OFF;
    wire logic cpl_pend     = cpl_q == msc_pkg::CPL_WAIT_ON || cpl_q == msc_pkg::CPL_WAIT_OFF;

    // ---- torque compensation
    logic comp_q;
    logic comp_pend_q;

    // a request raised outside the fine window waits for it instead of being lost
    wire logic comp_on  = tick && !comp_q && fine_q                          // [R2]
                          && (comp_rise || (comp_pend_q && comp_lvl));
    wire logic comp_off = comp_fall && comp_q;                              // [R3]

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            comp_q      <= 1'b0;
            comp_pend_q <= 1'b0;
        end
        else
        begin
            if (comp_on)
                comp_q <= 1'b1;
            else if (comp_off)
                comp_q <= 1'b0;
            if (comp_fall || comp_on)
                comp_pend_q <= 1'b0;
            else if (comp_rise)
                comp_pend_q <= 1'b1;
        end
    end

    // ---- status levels; only change on the interface cycle
    assign stat.couple_active          = coupled_now;   // [R14]
    assign stat.comp_active            = comp_q;        // [R12]
    assign stat.coarse_speed_tolerance = coarse_q;      // [R11]
    assign stat.fine_speed_tolerance   = fine_q;        // [R10]

    // ---- events and interrupt
    wire logic [msc_pkg::EV_W-1:0] ev_set = {
        (cpl_rise || cpl_fall) && !allowed,     // [R7]
        comp_off,
        comp_on,
        coupled_now && !coupled_next,
        !coupled_now && coupled_next
    };

    always_ff @(posedge clk)
    begin
        if (srst)
            ev_stat_q <= '0;
        else
            ev_stat_q <= (rd_stat ? '0 : ev_stat_q) | ev_set;
    end

    assign irq = |(ev_stat_q & ev_mask_q);

    // ---- read data, valid the cycle after the strobe only
    logic [msc_pkg::REG_DW-1:0] state_word;

    always_comb
    begin
        state_word                        = '0;
        state_word[msc_pkg::ST_FINE]      = fine_q;
        state_word[msc_pkg::ST_COARSE]    = coarse_q;
        state_word[msc_pkg::ST_COMP]      = comp_q;
        state_word[msc_pkg::ST_COUPLE]    = coupled_now;
        state_word[msc_pkg::ST_CPL_PEND]  = cpl_pend;
        state_word[msc_pkg::ST_COMP_PEND] = comp_pend_q;
    end

    wire logic [msc_pkg::REG_DW-1:0] rd_mux =
        reg_addr == msc_pkg::REG_FINE_TOL   ? DW'(fine_tol_q)   :
        reg_addr == msc_pkg::REG_COARSE_TOL ? DW'(coarse_tol_q) :
        reg_addr == msc_pkg::REG_STATE      ? state_word        :
        reg_addr == msc_pkg::REG_DIFF       ? DW'(diff_q)       :
        reg_addr == msc_pkg::REG_IRQ_STAT   ? DW'(ev_stat_q)    :
        reg_addr == msc_pkg::REG_IRQ_MASK   ? DW'(ev_mask_q)    :
                                              '0;

    always_ff @(posedge clk)
    begin
        if (srst)
            rdata_q <= '0;
        else
            rdata_q <= reg_rd ? rd_mux : '0;
    end

    assign reg_rdata = rdata_q;

    // ---- checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence cpl_changes_s;
        coupled_now != $past(coupled_now);
    endsequence

    sequence blocked_edge_s;
        (cpl_rise || cpl_fall) && !allowed;
    endsequence

    couple_gate_a: assert property ( // [R5]
        cpl_changes_s |-> $past(tick) && $past(pos_ok) && $past(still_ok))
        else $error("coupling changed without position control and standstill");

    chan_reset_a: assert property ( // [R6]
        cpl_changes_s |-> $past(chan_ok))
        else $error("coupling changed outside channel reset");

    blocked_hold_a: assert property ( // [R7]
        blocked_edge_s |=> $stable(coupled_now) && ev_stat_q[msc_pkg::EV_HELD])
        else $error("blocked request changed the coupling state");

    late_switch_a: assert property ( // [R8]
        tick && allowed && cpl_pend |=> coupled_now == $past(cpl_lvl) && !cpl_pend)
        else $error("pending coupling not resolved by request level");

    lead_ignored_a: assert property ( // [R9]
        tick && allowed && req.couple_req_follow && !cpl_pend |=> coupled_now)
        else $error("coupling did not follow the following axis request");

    comp_needs_fine_a: assert property ( // [R2]
        $rose(comp_q) |-> $past(fine_q) && $past(tick))
        else $error("compensation started outside fine window");

    comp_fall_off_a: assert property ( // [R3]
        comp_fall |=> !comp_q ##1 !comp_q)
        else $error("compensation still active after request fell");

    status_cycle_a: assert property ( // [R15]
        !$past(tick) |-> $stable(stat.couple_active) && $stable(stat.comp_active))
        else $error("status level moved between interface cycles");

    comp_active_a: assert property ( // [R12]
        comp_on |=> stat.comp_active && ev_stat_q[msc_pkg::EV_COMP_ON])
        else $error("compensation start not reported");

    read_clear_a: assert property (
        rd_stat && ev_set == '0 |=> ev_stat_q == '0)
        else $error("status read did not clear events");

endmodule // msc_coupling_ctrl

// ---- tb/msc_plc_model.sv ----
`timescale 1ns/1ns
module msc_plc_model (
    // clock
    input  wire logic                          clk,
    // status levels from the following axis
    input  wire msc_pkg::msc_stat_s            stat,
    // axis interface levels
    output msc_pkg::msc_req_s                  req,
    output msc_pkg::msc_cond_s                 cond,
    output logic      [msc_pkg::SPEED_W-1:0]   lead_speed,
    output logic      [msc_pkg::SPEED_W-1:0]   follow_speed,
    // compensation status as the program sees it
    output logic                               comp_seen
);
    initial
    begin
        req          = 3'h0;
        cond         = 6'h00;
        lead_speed   = 24'h000000;
        follow_speed = 24'h000000;
    end

    // levels are held until changed, so every tick sample sees them
    task automatic put(input logic [2:0] r, input logic [5:0] c);
        @(posedge clk);
        req  <= r;
        cond <= c;
    endtask

    task automatic speeds(input logic [23:0] l, input logic [23:0] f);
        @(posedge clk);
        lead_speed   <= l;
        follow_speed <= f;
    endtask

    // the lead copy is never looked at here
    assign comp_seen = stat.comp_active;
endmodule // msc_plc_model

// ---- tb/tb.sv ----
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin fails++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
    localparam int CYC = 4;
    logic                          clk       = 1'b0;
    logic                          srst      = 1'b1;
    logic [msc_pkg::REG_AW-1:0]    reg_addr  = 8'h00;
    logic [msc_pkg::REG_DW-1:0]    reg_wdata = 32'h00000000;
    logic                          reg_wr    = 1'b0;
    logic                          reg_rd    = 1'b0;
    logic [msc_pkg::REG_DW-1:0]    reg_rdata;
    logic                          irq;
    logic                          comp_seen;
    msc_pkg::msc_req_s             req;
    msc_pkg::msc_cond_s            cond;
    msc_pkg::msc_stat_s            stat;
    logic [msc_pkg::SPEED_W-1:0]   lead_speed;
    logic [msc_pkg::SPEED_W-1:0]   follow_speed;
    logic [31:0]                   rv;
    logic [23:0]                   ls [5] = '{24'h000100, 24'h000111, 24'hFFFFFB, 24'h000000, 24'h000000};
    logic [23:0]                   fs [5] = '{24'h000110, 24'h000100, 24'h00000B, 24'h000100, 24'h000101};
    logic [23:0]                   ds [5] = '{24'h000010, 24'h000011, 24'h000010, 24'h000100, 24'h000101};
    int                            fails  = 0;
    int                            checks = 0;
    int                            cyc_n  = 0;

    initial
    begin
        forever #5 clk = ~clk;
    end

    msc_coupling_ctrl #(.CYCLE_CLKS(CYC), .SPEED_W(msc_pkg::SPEED_W)) DUT (
        .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .req(req), .cond(cond), .lead_speed(lead_speed),
        .follow_speed(follow_speed), .stat(stat)
    );

    msc_plc_model plc (
        .clk(clk), .stat(stat), .req(req), .cond(cond), .lead_speed(lead_speed),
        .follow_speed(follow_speed), .comp_seen(comp_seen)
    );

    task automatic end_of_test();
        if (fails == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // every task starts at a rising edge so no signal is driven twice per step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        rv = reg_rdata;
    endtask

    // three interface cycles cover any tick phase plus the one-cycle answer
    task automatic settle();
        repeat (3 * CYC) @(posedge clk);
        #1;
    endtask

    always @(posedge clk)
    begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 5000)
        begin
            fails++;
            end_of_test();
        end
    end

    initial
    begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        rd(msc_pkg::REG_FINE_TOL);   `CHK("fine_tol", 32'h00000010, rv)
        rd(msc_pkg::REG_COARSE_TOL); `CHK("coarse_tol", 32'h00000100, rv)
        rd(msc_pkg::REG_IRQ_MASK);   `CHK("mask", 32'h00000000, rv)
        rd(8'h20);                   `CHK("unmapped", 32'h00000000, rv)
        // zero speeds after the first interface cycle lie inside both windows
        `CHK("stat_rst", 4'h3, stat)
        // window edges, inclusive, with a sign change across zero
        for (int i = 0; i < 5; i++)
        begin
            plc.speeds(ls[i], fs[i]);
            settle();
            `CHK("fine", ds[i] <= msc_pkg::FINE_TOL_RST, stat.fine_speed_tolerance)
            `CHK("coarse", ds[i] <= msc_pkg::COARSE_TOL_RST, stat.coarse_speed_tolerance)
            rd(msc_pkg::REG_DIFF);   `CHK("diff", {8'h00, ds[i]}, rv)
        end
        wr(msc_pkg::REG_FINE_TOL, 32'hFF000011);
        rd(msc_pkg::REG_FINE_TOL);   `CHK("fine_tol_wr", 32'h00000011, rv)
        plc.speeds(ls[1], fs[1]);
        settle();
        `CHK("fine_moved", 1'b1, stat.fine_speed_tolerance)
        wr(msc_pkg::REG_FINE_TOL, 32'h00000010);
        // compensation held back until fine is reached
        plc.speeds(ls[4], fs[4]);
        plc.put(3'h4, 6'h00);
        settle();
        `CHK("comp_nofine", 1'b0, stat.comp_active)
        rd(msc_pkg::REG_STATE);      `CHK("comp_pend", 32'h00000020, rv)
        plc.speeds(ls[0], fs[0]);
        settle();
        `CHK("comp_on", 1'b1, comp_seen)
        plc.speeds(ls[4], fs[4]);
        settle();
        `CHK("comp_keep", 1'b1, stat.comp_active)
        plc.put(3'h0, 6'h00);
        settle();
        `CHK("comp_off", 1'b0, stat.comp_active)
        rd(msc_pkg::REG_IRQ_STAT);   `CHK("ev_comp", 32'h0000000C, rv)
        rd(msc_pkg::REG_IRQ_STAT);   `CHK("ev_clr", 32'h00000000, rv)
        // coupling refused for each missing condition in turn
        wr(msc_pkg::REG_IRQ_MASK, 32'h00000001);
        for (int i = 0; i < 6; i++)
        begin
            plc.put(3'h1, 6'h3F ^ (6'h01 << i));
            settle();
            `CHK("cpl_held", 1'b0, stat.couple_active)
            `CHK("irq_held", 1'b0, irq)
        end
        plc.put(3'h1, 6'h3F);
        settle();
        `CHK("cpl_late", 1'b1, stat.couple_active)
        `CHK("irq_cpl", 1'b1, irq)
        rd(msc_pkg::REG_IRQ_STAT);   `CHK("ev_cpl", 32'h00000011, rv)
        #1;
        `CHK("irq_clr", 1'b0, irq)
        plc.put(3'h0, 6'h3E);
        settle();
        `CHK("dec_held", 1'b1, stat.couple_active)
        plc.put(3'h0, 6'h3F);
        settle();
        `CHK("dec_late", 1'b0, stat.couple_active)
        `CHK("irq_masked", 1'b0, irq)
        rd(msc_pkg::REG_IRQ_STAT);   `CHK("ev_dec", 32'h00000012, rv)
        // the lead copy of the request has no effect
        plc.put(3'h2, 6'h3F);
        settle();
        `CHK("lead_ign", 1'b0, stat.couple_active)
        plc.put(3'h1, 6'h3F);
        settle();
        `CHK("follow_cpl", 1'b1, stat.couple_active)
        wr(msc_pkg::REG_STATE, 32'hFFFFFFFF);
        rd(msc_pkg::REG_STATE);      `CHK("state_ro", 32'h00000008, rv)
        // held decouple, then the request returns before conditions do
        plc.put(3'h0, 6'h3E);
        settle();
        rd(msc_pkg::REG_STATE);      `CHK("dec_pend", 32'h00000018, rv)
        plc.put(3'h1, 6'h3E);
        settle();
        rd(msc_pkg::REG_STATE);      `CHK("pend_drop", 32'h00000008, rv)
        plc.put(3'h1, 6'h3F);
        // reset in mid-run; a request still high counts as a new edge
        @(posedge clk);
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        #1;
        `CHK("stat_rst2", 4'h0, stat)
        settle();
        `CHK("cpl_rst", 1'b1, stat.couple_active)
        end_of_test();
    end
endmodule // tb
